// ### blpl_core.sv
// Burst laser power loop: search, track, hold and gate of laser bias
//
// Overview of operation
// - Startup runs successive search on bias setting
// - Gate high: adjust bias toward monitor target
// - Gate low: freeze bias, resume next burst
// - Only power cycle or disable clears loop
// - Bias never above ceiling; loop only subtracts
// - Fail low during init and at ceiling
// - Fail low when minimum reached, still bright
// - Slow-start delay before loop initialisation
// - Disabled: outputs off, loop held reset
// - Disable fall starts init, 2.1/3.72us
// - Init coarse, then fine tracking mode
// - Power-up start takes 12us
// - Chip-enable start takes 2.1us
// - Gate never high: start on rise, 1.6us
// - Init ends by three bursts or time
// - After init outputs follow gate polarity
// - Outputs switch on promptly with gate
// - Outputs switch off promptly with gate
// - Shorted ceiling or swing: outputs off
// - Open loop: bias equals ceiling
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "blpl_params.svh"

module blpl_core
  import blpl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Device pins
  input  wire logic        supply_ok_i,
  input  wire logic        chip_disable_i,
  input  wire logic        burst_gate_p_i,
  input  wire logic        burst_gate_n_i,
  input  wire logic        extended_burst_select_i,
  input  wire logic        monitor_above_i,
  input  wire logic        ceiling_short_i,
  input  wire logic        swing_short_i,
  // Laser drive
  output logic             bias_on_o,
  output logic             mod_on_o,
  output logic      [7:0]  bias_code_o,
  output logic      [7:0]  swing_code_o,
  output logic             loop_fail_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  blpl_ctrl_s  ctrl_reg;
  blpl_state_e state_reg;
  logic [7:0]  sub_reg;
  logic [7:0]  step_reg;
  logic [11:0] cnt_reg;
  logic [11:0] dl_reg;
  logic [11:0] init_len_reg;
  logic [11:0] step_len_reg;
  logic [1:0]  bursts_reg;
  logic        gate_seen_reg;
  logic        pwr_cause_reg;
  logic        gate_q_reg;
  logic        gate;
  logic        disabled;
  logic        shorted;
  logic        in_init;
  logic        at_ceiling;
  logic        at_floor;
  logic        search_done;
  logic [8:0]  sub_up;
  logic [8:0]  sub_dn;
  logic        apb_do;

  // Differential gate: equal levels count as off
  assign gate     = burst_gate_p_i & ~burst_gate_n_i;
  assign disabled = chip_disable_i | ~supply_ok_i;
  assign shorted  = ceiling_short_i | swing_short_i;
  assign in_init  = (state_reg != ST_TRACK);
  // Ceiling hit means no bias left to add; floor means nothing to take
  assign at_ceiling = (sub_reg == 8'h00) & ~monitor_above_i;
  assign at_floor   = (sub_reg == ctrl_reg.ceiling) & monitor_above_i;
  assign search_done = (step_reg == 8'h00) | (dl_reg >= init_len_reg) |
                       (bursts_reg == `BLPL_MAX_BURSTS);
  assign sub_up = {1'b0, sub_reg} + {1'b0, step_reg};
  assign sub_dn = {1'b0, sub_reg} - {1'b0, step_reg};
  assign apb_do = psel_i & penable_i & pready_o;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registers answer on the second access cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
    end
  end

  // Control register write
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= blpl_ctrl_s'(`BLPL_CTRL_RST);
    end else if (apb_do && pwrite_i && paddr_i == `BLPL_CTRL_OFS) begin
      ctrl_reg.ceiling   <= pwdata_i[`BLPL_CEIL_LSB +: 8];
      ctrl_reg.swing     <= pwdata_i[`BLPL_SWING_LSB +: 8];
      ctrl_reg.open_loop <= pwdata_i[`BLPL_OPEN_BIT];
    end
  end

  // Read data and error answer, prepared on the first access cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (paddr_i == `BLPL_CTRL_OFS) begin
        prdata_o <= {15'h0000, ctrl_reg};
      end else if (paddr_i == `BLPL_STAT_OFS) begin
        if (pwrite_i) begin
          pslverr_o <= 1'b1;
        end
        prdata_o <= {11'h000, state_reg, loop_fail_n_o,
                     pwr_cause_reg, sub_reg, bias_code_o};
      end else begin
        pslverr_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start-case bookkeeping: power-up cause and whether gate was ever high
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwr_cause_reg <= 1'b1;
      gate_seen_reg <= 1'b0;
    end else begin
      // A chip that sat disabled on a good supply restarts as an enable
      if (!supply_ok_i) begin
        pwr_cause_reg <= 1'b1;
      end else if (chip_disable_i || state_reg == ST_TRACK) begin
        pwr_cause_reg <= 1'b0;
      end
      if (disabled) begin
        gate_seen_reg <= 1'b0;
      end else if (gate) begin
        gate_seen_reg <= 1'b1;
      end
    end
  end

  // Gate delay for burst-end counting
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gate_q_reg <= 1'b0;
    end else begin
      gate_q_reg <= gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Loop sequencer
  // Disable or supply loss wins over every state so the loop restarts
  // cleanly; a supply glitch cannot leave a half-done search behind.
  always_ff @(posedge clk_i) begin
    if (!rstn_i || disabled) begin
      state_reg    <= ST_OFF;
      cnt_reg      <= 12'h000;
      dl_reg       <= 12'h000;
      init_len_reg <= 12'h000;
      step_len_reg <= 12'h000;
      bursts_reg   <= 2'h0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_reg <= ST_SLOW;
          cnt_reg   <= 12'h000;
          if (pwr_cause_reg) begin
            init_len_reg <= 12'(`BLPL_PWR_CYC);
          end else if (extended_burst_select_i) begin
            init_len_reg <= 12'(`BLPL_EN_LONG_CYC);
          end else begin
            init_len_reg <= 12'(`BLPL_EN_CYC);
          end
        end
        ST_SLOW: begin
          if (cnt_reg >= 12'(`BLPL_SLOW_CYC - 1)) begin
            cnt_reg      <= 12'h000;
            dl_reg       <= 12'h000;
            bursts_reg   <= 2'h0;
            step_len_reg <= init_len_reg >> 3;
            if (ctrl_reg.open_loop) begin
              state_reg <= ST_TRACK;
            end else if (!gate_seen_reg && !gate) begin
              state_reg <= ST_WAIT_GATE;
            end else begin
              state_reg <= ST_SEARCH;
            end
          end else begin
            cnt_reg <= cnt_reg + 12'h001;
          end
        end
        ST_WAIT_GATE: begin
          if (gate) begin
            state_reg    <= ST_SEARCH;
            init_len_reg <= 12'(`BLPL_BURST_CYC);
            step_len_reg <= 12'(`BLPL_BURST_CYC) >> 3;
            cnt_reg      <= 12'h000;
            dl_reg       <= 12'h000;
          end
        end
        ST_SEARCH: begin
          dl_reg <= dl_reg + 12'h001;
          if (gate_q_reg && !gate && bursts_reg != `BLPL_MAX_BURSTS) begin
            bursts_reg <= bursts_reg + 2'h1;
          end
          if (search_done) begin
            state_reg <= ST_TRACK;
            cnt_reg   <= 12'h000;
          end else if (gate) begin
            // Step pace only runs while lit; monitor is meaningless dark
            cnt_reg <= (cnt_reg >= step_len_reg) ? 12'h000
                                                 : cnt_reg + 12'h001;
          end
        end
        ST_TRACK: begin
          if (gate) begin
            cnt_reg <= (cnt_reg >= `BLPL_TRACK_CYC) ? 12'h000
                                                    : cnt_reg + 12'h001;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bias subtraction from the ceiling: coarse halving steps, then unit
  always_ff @(posedge clk_i) begin
    if (!rstn_i || disabled) begin
      sub_reg  <= 8'h00;
      step_reg <= 8'h80;
    end else if (ctrl_reg.open_loop) begin
      sub_reg <= 8'h00;
    end else if (state_reg == ST_SEARCH && gate &&
                 cnt_reg >= step_len_reg && !search_done) begin
      // Bright: take more away; dim: give some back
      if (monitor_above_i) begin
        sub_reg <= (sub_up[8] || sub_up[7:0] > ctrl_reg.ceiling)
                   ? ctrl_reg.ceiling : sub_up[7:0];
      end else begin
        sub_reg <= sub_dn[8] ? 8'h00 : sub_dn[7:0];
      end
      step_reg <= step_reg >> 1;
    end else if (state_reg == ST_TRACK && gate &&
                 cnt_reg >= `BLPL_TRACK_CYC) begin
      if (monitor_above_i && !at_floor) begin
        sub_reg <= sub_reg + 8'h01;
      end else if (!monitor_above_i && sub_reg != 8'h00) begin
        sub_reg <= sub_reg - 8'h01;
      end
    end else if (sub_reg > ctrl_reg.ceiling) begin
      sub_reg <= ctrl_reg.ceiling;
    end
    // Gate low skips both step branches: value is held unless open loop or above ceiling
  end

  ////////////////////////////////////////////////////////////////////////
  // Laser drive outputs, one flop after the gate; the sub-cycle switching
  // times stay with the analog stage, this only steers it.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bias_on_o    <= 1'b0;
      mod_on_o     <= 1'b0;
      bias_code_o  <= 8'h00;
      swing_code_o <= 8'h00;
    end else begin
      bias_on_o <= gate & ~disabled & ~shorted &
                   (state_reg == ST_SEARCH || state_reg == ST_TRACK);
      mod_on_o  <= gate & ~disabled & ~shorted &
                   (state_reg == ST_SEARCH || state_reg == ST_TRACK);
      bias_code_o  <= (sub_reg > ctrl_reg.ceiling) ? 8'h00
                      : ctrl_reg.ceiling - sub_reg;
      swing_code_o <= ctrl_reg.swing;
    end
  end
  // Output timing follows the gate within one cycle

  // Failure flag, active low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      loop_fail_n_o <= 1'b0;
    end else if (disabled || in_init) begin
      loop_fail_n_o <= 1'b0;
    end else if (!ctrl_reg.open_loop && (at_ceiling || at_floor)) begin
      loop_fail_n_o <= 1'b0;
    end else begin
      loop_fail_n_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_disable_off: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    disabled |=> !bias_on_o && !mod_on_o)
    else $error("outputs on while disabled");
  a_short_off: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    shorted |=> !bias_on_o && !mod_on_o)
    else $error("outputs on during short");
  a_bias_ceiling: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    $stable(ctrl_reg.ceiling) |=> bias_code_o <= $past(ctrl_reg.ceiling))
    else $error("bias above ceiling");
  a_gate_hold: assert property (@(posedge clk_i)
    disable iff (!rstn_i || disabled)
    state_reg == ST_TRACK && !gate && !ctrl_reg.open_loop &&
    sub_reg <= ctrl_reg.ceiling |=> $stable(sub_reg))
    else $error("bias moved while gate low");
  a_fail_init: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    in_init |=> !loop_fail_n_o)
    else $error("fail high during init");
  a_fail_floor: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    state_reg == ST_TRACK && !disabled && !ctrl_reg.open_loop &&
    at_floor |=> !loop_fail_n_o)
    else $error("fail high at minimum bias");
  // Full slow-start length: 45 cycles in SLOW, then out of it
  a_slow_len: assert property (@(posedge clk_i)
    disable iff (!rstn_i || disabled)
    $rose(state_reg == ST_SLOW) |-> (state_reg == ST_SLOW) [*8]
    ##37 (state_reg == ST_SLOW) ##1 (state_reg != ST_SLOW))
    else $error("slow start cut short");
  a_search_bound: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    state_reg == ST_SEARCH |-> dl_reg <= init_len_reg)
    else $error("search overran its deadline");
  a_open_bias: assert property (@(posedge clk_i)
    disable iff (!rstn_i || disabled)
    ctrl_reg.open_loop && $stable(ctrl_reg) |=>
    bias_code_o == ctrl_reg.ceiling)
    else $error("open loop bias not at ceiling");
  a_off_gate: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    !gate |=> !bias_on_o)
    else $error("bias on without gate");
  a_fail_clear: assert property (@(posedge clk_i)
    disable iff (!rstn_i)
    !in_init && !disabled &&
    (ctrl_reg.open_loop || (!at_ceiling && !at_floor)) |=> loop_fail_n_o)
    else $error("fail low while tracking in range");
  c_power: cover property (@(posedge clk_i) disable iff (!rstn_i)
    pwr_cause_reg && state_reg == ST_SEARCH);
  c_track: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_reg == ST_SEARCH ##1 state_reg == ST_TRACK);
  c_wait_gate: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_reg == ST_WAIT_GATE ##1 state_reg == ST_SEARCH);
  c_fail_track: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_reg == ST_TRACK && !loop_fail_n_o);
  c_burst_end: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_reg == ST_SEARCH && bursts_reg == `BLPL_MAX_BURSTS);

endmodule : blpl_core
`default_nettype wire

// ### blpl_laser_model.sv
// Laser diode with back-facet monitor, compared against a power target
`timescale 1ns/100ps
`default_nettype none

module blpl_laser_model (
  // Drive coming from the block
  input  wire logic       bias_on_i,
  input  wire logic [7:0] bias_code_i,
  // Operating point chosen by the bench
  input  wire logic [7:0] target_i,
  input  wire logic       shorted_i,
  // Monitor comparison back to the block
  output logic            monitor_above_o
);
  // A dark laser gives no photocurrent; a shorted cathode glows regardless
  assign monitor_above_o = shorted_i | (bias_on_i & (bias_code_i > target_i));
endmodule : blpl_laser_model

`default_nettype wire

// ### blpl_params.svh
// Constants of the burst laser power loop: offsets, fields, resets, timing
`ifndef BLPL_PARAMS_SVH
`define BLPL_PARAMS_SVH
// Register byte offsets
`define BLPL_CTRL_OFS      12'h000
`define BLPL_STAT_OFS      12'h004
// Control register fields
`define BLPL_CEIL_LSB      0
`define BLPL_SWING_LSB     8
`define BLPL_OPEN_BIT      16
`define BLPL_CTRL_RST      32'h0000_0000
// Tracking pace: cycles between fine steps
`define BLPL_TRACK_CYC     12'h010
// Clock period and typical times
`define BLPL_CLK_NS        10
`define BLPL_SLOW_NS       450
`define BLPL_EN_NS         2100
`define BLPL_EN_LONG_NS    3720
`define BLPL_PWR_NS        12000
`define BLPL_BURST_NS      1600
// Cycle counts derived from the times
`define BLPL_SLOW_CYC      (`BLPL_SLOW_NS / `BLPL_CLK_NS)
`define BLPL_EN_CYC        (`BLPL_EN_NS / `BLPL_CLK_NS)
`define BLPL_EN_LONG_CYC   (`BLPL_EN_LONG_NS / `BLPL_CLK_NS)
`define BLPL_PWR_CYC       (`BLPL_PWR_NS / `BLPL_CLK_NS)
`define BLPL_BURST_CYC     (`BLPL_BURST_NS / `BLPL_CLK_NS)
// Search ends after this many completed bursts
`define BLPL_MAX_BURSTS    2'h3
`endif

// ### blpl_pkg.sv
// Types shared by the burst laser power loop
package blpl_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_SLOW, ST_WAIT_GATE, ST_SEARCH, ST_TRACK
  } blpl_state_e;
  typedef struct packed {
    logic       open_loop;
    logic [7:0] swing;
    logic [7:0] ceiling;
  } blpl_ctrl_s;
endpackage : blpl_pkg

// ### tb_burst_laser_power_loop.sv
// Self-checking bench of the burst laser power loop
`timescale 1ns/100ps
`default_nettype none
`include "blpl_params.svh"

module tb_burst_laser_power_loop;
  import blpl_pkg::*;
  logic        clk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        sup_ok, dis, gp, gn, ext, mon, c_sh, s_sh, shorted, e;
  logic        bias_on, mod_on, fail_n;
  logic [7:0]  bias_code, swing_code, target, hold;
  int          error_cnt, num_checks, n;

  blpl_core blpl_core_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .supply_ok_i(sup_ok), .chip_disable_i(dis),
    .burst_gate_p_i(gp), .burst_gate_n_i(gn), .extended_burst_select_i(ext),
    .monitor_above_i(mon), .ceiling_short_i(c_sh), .swing_short_i(s_sh),
    .bias_on_o(bias_on), .mod_on_o(mod_on), .bias_code_o(bias_code),
    .swing_code_o(swing_code), .loop_fail_n_o(fail_n));
  blpl_laser_model blpl_laser_model_inst (.bias_on_i(bias_on),
    .bias_code_i(bias_code), .target_i(target), .shorted_i(shorted),
    .monitor_above_o(mon));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task tmo(input string nm);
    error_cnt++;
    $display("wrong value %s exp done got timeout", nm);
    summarize;
  endtask : tmo

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) tmo("pready");
  endtask : apb

  task gate(input logic on);
    gp <= on;
    gn <= ~on;
  endtask : gate

  // Poll the state field; n returns the cycles spent
  task wait_st(input logic [2:0] st, input int lim);
    time t0;
    t0 = $time;
    q = '0;
    n = 0;
    while (q[20:18] !== st && n < lim) begin
      apb(1'b0, `BLPL_STAT_OFS, '0);
      n = int'(($time - t0) / 10);
    end
    if (q[20:18] !== st) tmo("state");
  endtask : wait_st

  task wait_fail(input logic v, input int lim);
    int k;
    k = 0;
    while (fail_n !== v && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    if (fail_n !== v) tmo("fail flag");
  endtask : wait_fail

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs;
    apb(1'b0, `BLPL_CTRL_OFS, '0);
    chk("ctrl reset", `BLPL_CTRL_RST, q);
    apb(1'b0, 12'h008, '0);
    chk("unmapped err", 1, e);
    apb(1'b1, `BLPL_STAT_OFS, 32'hffff_ffff);
    chk("status write err", 1, e);
    apb(1'b1, `BLPL_CTRL_OFS, 32'h0000_40c8);
    apb(1'b0, `BLPL_CTRL_OFS, '0);
    chk("ctrl back", 32'h0000_40c8, q);
    $display("test regs done");
  endtask : t_regs

  // Both extended-select levels, gate held high throughout
  task t_enable;
    for (int i = 0; i < 2; i++) begin
      dis <= 1'b1;
      ext <= i[0];
      cyc(3);
      chk("disabled bias", 0, bias_on);
      chk("disabled mod", 0, mod_on);
      dis <= 1'b0;
      cyc(20);
      chk("slow bias", 0, bias_on);
      chk("init fail", 0, fail_n);
      wait_st(3'h4, i ? 410 : 250);
      chk("slow passed", 1, n > 22);
      cyc(250);
      chk("track fail", 1, fail_n);
      chk("track near", 1, bias_code > 117 && bias_code < 123);
      chk("swing", 8'h40, swing_code);
    end
    $display("test enable done");
  endtask : t_enable

  task t_gate;
    gate(1'b0);
    cyc(2);
    chk("off bias", 0, bias_on);
    chk("off mod", 0, mod_on);
    hold = bias_code;
    cyc(200);
    chk("frozen", hold, bias_code);
    gate(1'b1);
    cyc(2);
    chk("on bias", 1, bias_on);
    chk("on mod", 1, mod_on);
    $display("test gate done");
  endtask : t_gate

  task t_limits;
    target <= 8'hfa;
    wait_fail(1'b0, 3000);
    chk("at ceiling", 8'hc8, bias_code);
    target <= 8'h78;
    shorted <= 1'b1;
    wait_fail(1'b1, 300);
    wait_fail(1'b0, 4000);
    chk("at floor", 8'h00, bias_code);
    shorted <= 1'b0;
    $display("test limits done");
  endtask : t_limits

  task t_open_short;
    apb(1'b1, `BLPL_CTRL_OFS, 32'h0001_4055);
    cyc(3);
    chk("open bias", 8'h55, bias_code);
    c_sh <= 1'b1;
    cyc(2);
    chk("ceil short", 0, bias_on | mod_on);
    c_sh <= 1'b0;
    s_sh <= 1'b1;
    cyc(2);
    chk("swing short", 0, bias_on | mod_on);
    s_sh <= 1'b0;
    apb(1'b1, `BLPL_CTRL_OFS, 32'h0000_40c8);
    $display("test open short done");
  endtask : t_open_short

  task t_burst;
    dis <= 1'b1;
    gate(1'b0);
    ext <= 1'b0;
    cyc(3);
    dis <= 1'b0;
    cyc(100);
    apb(1'b0, `BLPL_STAT_OFS, '0);
    chk("wait gate", 3'h2, q[20:18]);
    gate(1'b1);
    wait_st(3'h4, 175);
    dis <= 1'b1;
    ext <= 1'b1;
    cyc(3);
    dis <= 1'b0;
    cyc(60);
    gate(1'b0);
    repeat (2) begin
      cyc(12);
      gate(1'b1);
      cyc(60);
      gate(1'b0);
    end
    cyc(3);
    gate(1'b1);
    apb(1'b0, `BLPL_STAT_OFS, '0);
    chk("three bursts", 3'h4, q[20:18]);
    $display("test burst done");
  endtask : t_burst

  task t_power;
    sup_ok <= 1'b0;
    ext <= 1'b0;
    cyc(3);
    chk("no supply", 0, bias_on);
    sup_ok <= 1'b1;
    apb(1'b0, `BLPL_STAT_OFS, '0);
    chk("power cause", 1, q[16]);
    wait_st(3'h4, 1260);
    chk("power time", 1, n > 1100);
    $display("test power done");
  endtask : t_power

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; gate held high means continuous mode
  initial begin
    rstn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sup_ok = 1'b1;
    dis = 1'b1;
    gp = 1'b1;
    gn = 1'b0;
    ext = 1'b0;
    c_sh = 1'b0;
    s_sh = 1'b0;
    shorted = 1'b0;
    target = 8'h78;
    cyc(10);
    rstn_i <= 1'b1;
    t_regs;
    t_enable;
    t_gate;
    t_limits;
    t_open_short;
    t_burst;
    t_power;
    summarize;
  end
endmodule : tb_burst_laser_power_loop

`default_nettype wire
